/* File: lsu_top.sv */
// Load/store execution unit: address generation, single and multiple
// transfers, push and pop, with its own low registers and stack pointer.
// Assumes a memory that answers each held request with a one-cycle ack.
`timescale 1ns/1ps
`include "lsu_params.svh"

//Overview of operation
// - Address generate writes program counter plus immediate.
// - Generated target word aligned, within 1020 bytes.
// - Unsigned byte and half loads zero-extend.
// - Stores write word, low byte, low half.
// - Immediate forms address base plus constant offset.
// - Offset ranges depend on base and size.
// - Single access address aligned to its size.
// - Unaligned access raises alignment fault instead.
// - Register offset address is base plus offset.
// - Signed byte and half loads sign-extend.
// - Register offset forms use low registers only.
// - No instruction here changes condition flags.
// - Literal load fetches aligned word near counter.
// - Counter used reads instruction address plus four.
// - Multiples step four bytes from base upward.
// - Lowest register pairs with lowest address.
// - Writeback stores base plus four times count.
// - Stores write back; loads skip if base listed.
// - Multiples use low registers, aligned base.
// - Push stores below stack pointer, then lowers it.
// - Pop loads upward from stack pointer, raises it.
// - Pop of counter branches, bit zero to state.
// - Push and pop lists non-empty and restricted.
module lsu_top
    import lsu_pkg::*;
(
    // Clock and reset.
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    // Instruction issue and completion.
    input  wire logic [15:0] INSTR_I,
    input  wire logic [31:0] INSTR_ADDR_I,
    input  wire logic        INSTR_VALID_I,
    output logic             READY_O,
    output logic             DONE_O,
    output logic             FAULT_O,
    output logic             BRANCH_O,
    output logic [31:0]      BRANCH_ADDR_O,
    output logic             TBIT_O,
    // Memory system.
    output logic             MEM_REQ_O,
    output logic             MEM_WE_O,
    output logic [31:0]      MEM_ADDR_O,
    output logic [3:0]       MEM_BE_O,
    output logic [31:0]      MEM_WDATA_O,
    input  wire logic [31:0] MEM_RDATA_I,
    input  wire logic        MEM_ACK_I,
    // Register and flag access.
    input  wire logic        REG_WR_I,
    input  wire logic [3:0]  REG_SEL_I,
    input  wire logic [31:0] REG_WDATA_I,
    output logic [31:0]      REG_RDATA_O,
    input  wire logic        FLAGS_WR_I,
    input  wire logic [3:0]  FLAGS_I,
    output logic [3:0]       FLAGS_O
);
    // ****************************************************************
    // Declarations and helpers
    // ****************************************************************
    lsu_dec_if   d ();
    logic [31:0] gpr_r [0:7];
    logic [31:0] sp_r;
    logic [31:0] lr_r;
    lsu_state_t  state_r;
    lsu_op_t     op_r;
    lsu_size_t   size_r;
    logic        load_r, sgn_r, wb_en_r, wb_sp_r;
    logic [2:0]  rt_r, wb_rn_r;
    logic [8:0]  list_r;
    logic [31:0] wb_val_r;
    logic        accept, bad, multi_r, last, a_en, b_en;
    logic [31:0] base_val, off_val, pc_ahead, n_bytes, start_addr, wb_val_nxt;
    logic [31:0] ld_lane, ld_ext, a_data;
    logic [8:0]  start_list, rem_list;
    logic [3:0]  cur_idx;
    logic [2:0]  a_sel;
    logic        wb_en_nxt, wb_sp_nxt;

    function automatic logic [3:0] low_bit(input logic [8:0] l);
        low_bit = 4'h0;
        for (int i = 8; i >= 0; i--) if (l[i]) low_bit = 4'(i);
    endfunction

    function automatic logic [3:0] count(input logic [8:0] l);
        count = 4'h0;
        for (int i = 0; i < 9; i++) count = count + {3'h0, l[i]};
    endfunction

    function automatic logic misaligned(input logic [31:0] a, input lsu_size_t s);
        case (s)
            LSU_SZ_WORD: misaligned = (a[1:0] != 2'b00);
            LSU_SZ_HALF: misaligned = a[0];
            default:     misaligned = 1'b0;
        endcase
    endfunction

    // List index eight is the link register when it is a store source.
    function automatic logic [31:0] reg_val(input logic [3:0] sel);
        if (sel == `LSU_SP_SEL) reg_val = sp_r;
        else if (sel == `LSU_LR_SEL || sel == `LSU_XTRA_IDX) reg_val = lr_r;
        else if (sel[3] == 1'b0) reg_val = gpr_r[sel[2:0]];
        else reg_val = `LSU_REG_RST;
    endfunction

    // Narrow stores replicate into every lane; the enables pick the lane.
    function automatic logic [31:0] lanes(input logic [31:0] v, input lsu_size_t s);
        case (s)
            LSU_SZ_BYTE: lanes = {4{v[7:0]}};
            LSU_SZ_HALF: lanes = {2{v[15:0]}};
            default:     lanes = v;
        endcase
    endfunction

    function automatic logic [3:0] be_of(input logic [1:0] a, input lsu_size_t s);
        case (s)
            LSU_SZ_BYTE: be_of = 4'(4'h1 << a);
            LSU_SZ_HALF: be_of = a[1] ? 4'hc : 4'h3;
            default:     be_of = 4'hf;
        endcase
    endfunction

    assign d.instr = INSTR_I;

    lsu_decode u_decode (
        .d (d.dec)
    );

    // ****************************************************************
    // Start of an instruction
    // ****************************************************************
    assign accept = READY_O & INSTR_VALID_I;

    // Address of the first access, list and writeback, all from decode.
    always_comb begin
        base_val   = d.sp_base ? sp_r : gpr_r[d.rn];
        off_val    = d.reg_off ? gpr_r[d.rm] : {22'h0, d.imm};
        pc_ahead   = (INSTR_ADDR_I + `LSU_PC_AHEAD) & `LSU_ALIGN_MSK;
        n_bytes    = {26'h0, count(d.list), 2'b00};
        start_addr = base_val + off_val;
        start_list = 9'h001;
        wb_en_nxt  = 1'b0;
        wb_sp_nxt  = 1'b0;
        wb_val_nxt = gpr_r[d.rn] + n_bytes;
        case (d.op)
            LSU_OP_ADR, LSU_OP_LIT: start_addr = pc_ahead + {22'h0, d.imm};
            LSU_OP_MULTI: begin
                start_addr = gpr_r[d.rn];
                start_list = d.list;
                wb_en_nxt  = ~d.load | ~d.list[d.rn];
            end
            LSU_OP_PUSH: begin
                start_addr = sp_r - n_bytes;
                start_list = d.list;
                wb_en_nxt  = 1'b1;
                wb_sp_nxt  = 1'b1;
                wb_val_nxt = sp_r - n_bytes;
            end
            LSU_OP_POP: begin
                start_addr = sp_r;
                start_list = d.list;
                wb_en_nxt  = 1'b1;
                wb_sp_nxt  = 1'b1;
                wb_val_nxt = sp_r + n_bytes;
            end
            default: start_addr = base_val + off_val;
        endcase
        // Empty lists and unaligned addresses never reach the bus; unknown codes never fault.
        bad = (d.op != LSU_OP_NONE && misaligned(start_addr, d.size))
            | ((d.op == LSU_OP_MULTI || d.op == LSU_OP_PUSH || d.op == LSU_OP_POP)
               && d.list == 9'h000);
    end

    // ****************************************************************
    // Transfer sequencing
    // ****************************************************************
    assign multi_r  = (op_r == LSU_OP_MULTI) | (op_r == LSU_OP_PUSH) | (op_r == LSU_OP_POP);
    assign cur_idx  = low_bit(list_r);
    assign rem_list = list_r & ~(9'h001 << cur_idx);
    assign last     = (rem_list == 9'h000);

    // Load lane extraction and extension.
    always_comb begin
        ld_lane = MEM_RDATA_I >> {MEM_ADDR_O[1:0], 3'b000};
        case (size_r)
            LSU_SZ_BYTE: ld_ext = sgn_r ? {{24{ld_lane[7]}}, ld_lane[7:0]}
                                        : {24'h0, ld_lane[7:0]};
            LSU_SZ_HALF: ld_ext = sgn_r ? {{16{ld_lane[15]}}, ld_lane[15:0]}
                                        : {16'h0, ld_lane[15:0]};
            default:     ld_ext = ld_lane;
        endcase
    end

    // The request is held until acked; multiples walk the list upward.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_r     <= LSU_ST_IDLE;
            MEM_REQ_O   <= 1'b0;
            MEM_WE_O    <= 1'b0;
            MEM_ADDR_O  <= `LSU_REG_RST;
            MEM_BE_O    <= 4'h0;
            MEM_WDATA_O <= `LSU_REG_RST;
            list_r      <= 9'h000;
            op_r        <= LSU_OP_NONE;
            size_r      <= LSU_SZ_WORD;
            load_r      <= 1'b0;
            sgn_r       <= 1'b0;
            rt_r        <= 3'h0;
        end else begin
            case (state_r)
                LSU_ST_IDLE: begin
                    if (accept && !bad && d.op != LSU_OP_NONE && d.op != LSU_OP_ADR) begin
                        state_r     <= LSU_ST_MEM;
                        MEM_REQ_O   <= 1'b1;
                        MEM_WE_O    <= ~d.load;
                        MEM_ADDR_O  <= start_addr;
                        MEM_BE_O    <= be_of(start_addr[1:0], d.size);
                        MEM_WDATA_O <= lanes(reg_val(d.op == LSU_OP_ONE ? {1'b0, d.rt}
                                             : low_bit(start_list)), d.size);
                        list_r      <= start_list;
                        op_r        <= d.op;
                        size_r      <= d.size;
                        load_r      <= d.load;
                        sgn_r       <= d.sgn;
                        rt_r        <= d.rt;
                    end
                end
                LSU_ST_MEM: begin
                    if (MEM_ACK_I) begin
                        list_r <= rem_list;
                        if (last) begin
                            state_r   <= LSU_ST_IDLE;
                            MEM_REQ_O <= 1'b0;
                            MEM_WE_O  <= 1'b0;
                        end else begin
                            MEM_ADDR_O  <= MEM_ADDR_O + `LSU_WORD_STEP;
                            MEM_WDATA_O <= reg_val(low_bit(rem_list));
                        end
                    end
                end
                default: state_r <= LSU_ST_IDLE;
            endcase
        end
    end

    // Writeback is latched at the start so the base is read before any load.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            wb_en_r  <= 1'b0;
            wb_sp_r  <= 1'b0;
            wb_rn_r  <= 3'h0;
            wb_val_r <= `LSU_REG_RST;
        end else if (accept) begin
            wb_en_r  <= wb_en_nxt;
            wb_sp_r  <= wb_sp_nxt;
            wb_rn_r  <= d.rn;
            wb_val_r <= wb_val_nxt;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    // Port A takes address results and load data; port B takes writeback.
    always_comb begin
        a_en   = 1'b0;
        a_sel  = d.rt;
        a_data = start_addr;
        if (accept && d.op == LSU_OP_ADR) begin
            a_en = 1'b1;
        end else if (state_r == LSU_ST_MEM && MEM_ACK_I && load_r
                     && !(multi_r && cur_idx == `LSU_XTRA_IDX)) begin
            a_en   = 1'b1;
            a_sel  = multi_r ? cur_idx[2:0] : rt_r;
            a_data = ld_ext;
        end
    end
    assign b_en = (state_r == LSU_ST_MEM) & MEM_ACK_I & last & wb_en_r;

    // Outside writes land only while idle, so they never race a transfer.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < 8; i++) gpr_r[i] <= `LSU_REG_RST;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (REG_WR_I && READY_O && REG_SEL_I == 4'(i)) gpr_r[i] <= REG_WDATA_I;
                if (a_en && a_sel == 3'(i)) gpr_r[i] <= a_data;
                if (b_en && !wb_sp_r && wb_rn_r == 3'(i)) gpr_r[i] <= wb_val_r;
            end
        end
    end

    // Stack pointer moves only on an outside write or at the end of a push or pop.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            sp_r <= `LSU_REG_RST;
            lr_r <= `LSU_REG_RST;
        end else begin
            if (REG_WR_I && READY_O && REG_SEL_I == `LSU_SP_SEL) sp_r <= REG_WDATA_I;
            if (REG_WR_I && READY_O && REG_SEL_I == `LSU_LR_SEL) lr_r <= REG_WDATA_I;
            if (b_en && wb_sp_r) sp_r <= wb_val_r;
        end
    end

    // Flags are only ever loaded from outside; no access here touches them.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) FLAGS_O <= `LSU_FLAGS_RST;
        else if (FLAGS_WR_I) FLAGS_O <= FLAGS_I;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) REG_RDATA_O <= `LSU_REG_RST;
        else REG_RDATA_O <= reg_val(REG_SEL_I);
    end

    // ****************************************************************
    // Completion, fault and branch
    // ****************************************************************
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            READY_O       <= 1'b1;
            DONE_O        <= 1'b0;
            FAULT_O       <= 1'b0;
            BRANCH_O      <= 1'b0;
            BRANCH_ADDR_O <= `LSU_REG_RST;
            TBIT_O        <= `LSU_TBIT_RST;
        end else begin
            READY_O  <= (state_r == LSU_ST_IDLE)
                        ? !(accept && !bad && d.op != LSU_OP_NONE && d.op != LSU_OP_ADR)
                        : (MEM_ACK_I && last);
            DONE_O   <= (accept && !bad && (d.op == LSU_OP_NONE || d.op == LSU_OP_ADR))
                        || (state_r == LSU_ST_MEM && MEM_ACK_I && last);
            FAULT_O  <= accept && bad;
            BRANCH_O <= 1'b0;
            // The counter is always the highest pop entry, hence the last.
            if (state_r == LSU_ST_MEM && MEM_ACK_I && op_r == LSU_OP_POP
                && cur_idx == `LSU_XTRA_IDX) begin
                BRANCH_O      <= 1'b1;
                BRANCH_ADDR_O <= {ld_ext[31:1], 1'b0};
                TBIT_O        <= ld_ext[0];
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    property p_flags_kept;
        !FLAGS_WR_I |=> FLAGS_O == $past(FLAGS_O);
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("Flags changed without a flag write.");

    property p_unaligned_fault;
        accept && d.op == LSU_OP_ONE && misaligned(start_addr, d.size)
            |=> FAULT_O && !MEM_REQ_O;
    endproperty
    a_unaligned_fault: assert property (p_unaligned_fault)
        else $error("Unaligned access did not fault.");

    property p_bus_aligned;
        MEM_REQ_O |-> !misaligned(MEM_ADDR_O, size_r);
    endproperty
    a_bus_aligned: assert property (p_bus_aligned)
        else $error("Unaligned address on the bus.");

    property p_step_four;
        state_r == LSU_ST_MEM && MEM_ACK_I && !last
            |=> MEM_ADDR_O == $past(MEM_ADDR_O) + 32'h4 && MEM_REQ_O;
    endproperty
    a_step_four: assert property (p_step_four)
        else $error("Multiple transfer did not step by four.");

    property p_adr_value;
        accept && d.op == LSU_OP_ADR
            |=> gpr_r[$past(d.rt)] == (($past(INSTR_ADDR_I) + 32'h4) & 32'hffff_fffc)
                + {22'h0, $past(d.imm)} && DONE_O;
    endproperty
    a_adr_value: assert property (p_adr_value)
        else $error("Address generate wrote a wrong value.");

    property p_zero_ext;
        state_r == LSU_ST_MEM && MEM_ACK_I && load_r && !multi_r && !sgn_r
            && size_r == LSU_SZ_BYTE |=> gpr_r[$past(rt_r)][31:8] == 24'h0;
    endproperty
    a_zero_ext: assert property (p_zero_ext)
        else $error("Unsigned byte load not zero extended.");

    property p_sign_ext;
        state_r == LSU_ST_MEM && MEM_ACK_I && load_r && sgn_r && size_r == LSU_SZ_HALF
            |=> gpr_r[$past(rt_r)][31:16] == {16{$past(ld_lane[15])}};
    endproperty
    a_sign_ext: assert property (p_sign_ext)
        else $error("Signed halfword load not sign extended.");

    property p_byte_lane;
        MEM_REQ_O && MEM_WE_O && size_r == LSU_SZ_BYTE
            |-> $onehot(MEM_BE_O) && MEM_WDATA_O[31:24] == MEM_WDATA_O[7:0];
    endproperty
    a_byte_lane: assert property (p_byte_lane)
        else $error("Byte store drives more than one lane.");

    property p_push_start;
        accept && d.op == LSU_OP_PUSH && !bad
            |=> MEM_ADDR_O == $past(sp_r) - {26'h0, count($past(d.list)), 2'b00};
    endproperty
    a_push_start: assert property (p_push_start)
        else $error("Push started at a wrong address.");

    property p_pop_branch;
        BRANCH_O |-> BRANCH_ADDR_O[0] == 1'b0 && DONE_O && sp_r == $past(wb_val_r);
    endproperty
    a_pop_branch: assert property (p_pop_branch)
        else $error("Pop branch or stack update wrong.");

    c_push: cover property (accept && d.op == LSU_OP_PUSH && !bad);
    c_pop_pc: cover property (BRANCH_O);
    c_fault: cover property (FAULT_O);
endmodule // lsu_top

/* File: lsu_params.svh */
// Constants of the load/store unit: steps, selectors and reset values.
// Assumes inclusion by the top design module lsu_top only.
`ifndef LSU_PARAMS_SVH
`define LSU_PARAMS_SVH
`define LSU_PC_AHEAD  32'h0000_0004
`define LSU_WORD_STEP 32'h0000_0004
`define LSU_ALIGN_MSK 32'hffff_fffc
`define LSU_REG_RST   32'h0000_0000
`define LSU_FLAGS_RST 4'h0
`define LSU_TBIT_RST  1'b1
`define LSU_XTRA_IDX  4'h8
`define LSU_SP_SEL    4'hd
`define LSU_LR_SEL    4'he
`endif

/* File: lsu_pkg.sv */
// Types shared by the load/store unit modules.
// Assumes nothing beyond a SystemVerilog compiler.
package lsu_pkg;
    typedef enum logic [2:0] {
        LSU_OP_NONE, LSU_OP_ADR, LSU_OP_ONE, LSU_OP_LIT,
        LSU_OP_MULTI, LSU_OP_PUSH, LSU_OP_POP
    } lsu_op_t;
    typedef enum logic [1:0] {LSU_SZ_BYTE, LSU_SZ_HALF, LSU_SZ_WORD} lsu_size_t;
    typedef enum logic {LSU_ST_IDLE, LSU_ST_MEM} lsu_state_t;
endpackage

/* File: lsu_dec_if.sv */
// Interface carrying the instruction word and its decoded fields.
// Assumes the core drives the word and the decoder answers combinationally.
`timescale 1ns/1ps
interface lsu_dec_if;
    import lsu_pkg::*;
    logic [15:0] instr;
    lsu_op_t     op;
    lsu_size_t   size;
    logic        load;
    logic        sgn;
    logic        reg_off;
    logic        sp_base;
    logic [2:0]  rt;
    logic [2:0]  rn;
    logic [2:0]  rm;
    logic [9:0]  imm;
    logic [8:0]  list;
    modport dec  (input instr, output op, size, load, sgn, reg_off, sp_base,
                  rt, rn, rm, imm, list);
    modport core (output instr, input op, size, load, sgn, reg_off, sp_base,
                  rt, rn, rm, imm, list);
endinterface

/* File: lsu_decode.sv */
// Field decoder for the 16-bit memory access instructions.
// Assumes the core holds the instruction word steady while it reads fields.
`timescale 1ns/1ps
module lsu_decode
    import lsu_pkg::*;
(
    // Decoded fields towards the core.
    lsu_dec_if.dec d
);
    // Register fields are three bits wide, so only low registers are named.
    always_comb begin
        d.op      = LSU_OP_NONE;
        d.size    = LSU_SZ_WORD;
        d.load    = d.instr[11];
        d.sgn     = 1'b0;
        d.reg_off = 1'b0;
        d.sp_base = 1'b0;
        d.rt      = d.instr[2:0];
        d.rn      = d.instr[5:3];
        d.rm      = d.instr[8:6];
        d.imm     = 10'h000;
        d.list    = {1'b0, d.instr[7:0]};
        casez (d.instr[15:9])
            7'b10100??, 7'b01001??: begin
                // Offsets are scaled by four, so they reach 1020 at most.
                d.op   = d.instr[14] ? LSU_OP_LIT : LSU_OP_ADR;
                d.load = d.instr[14];
                d.rt   = d.instr[10:8];
                d.imm  = {d.instr[7:0], 2'b00};
            end
            7'b0101???: begin
                d.op      = LSU_OP_ONE;
                d.reg_off = 1'b1;
                d.load    = d.instr[11] | (d.instr[10:9] == 2'b11);
                d.sgn     = (d.instr[10:9] == 2'b11);
                case (d.instr[10:9])
                    2'b00:   d.size = LSU_SZ_WORD;
                    2'b01:   d.size = LSU_SZ_HALF;
                    2'b10:   d.size = LSU_SZ_BYTE;
                    default: d.size = d.instr[11] ? LSU_SZ_HALF : LSU_SZ_BYTE;
                endcase
            end
            7'b011????: begin
                d.op   = LSU_OP_ONE;
                d.size = d.instr[12] ? LSU_SZ_BYTE : LSU_SZ_WORD;
                d.imm  = d.instr[12] ? {5'h00, d.instr[10:6]}
                                     : {3'h0, d.instr[10:6], 2'b00};
            end
            7'b1000???: begin
                d.op   = LSU_OP_ONE;
                d.size = LSU_SZ_HALF;
                d.imm  = {4'h0, d.instr[10:6], 1'b0};
            end
            7'b1001???: begin
                d.op      = LSU_OP_ONE;
                d.sp_base = 1'b1;
                d.rt      = d.instr[10:8];
                d.imm     = {d.instr[7:0], 2'b00};
            end
            7'b1100???: begin
                d.op = LSU_OP_MULTI;
                d.rn = d.instr[10:8];
            end
            7'b1011010, 7'b1011110: begin
                // The ninth list bit is the link register or the program counter.
                d.op   = d.instr[11] ? LSU_OP_POP : LSU_OP_PUSH;
                d.list = d.instr[8:0];
            end
            default: d.op = LSU_OP_NONE;
        endcase
    end
endmodule // lsu_decode

/* File: lsu_mem_model.sv */
// Memory system model on the data port of the load/store unit.
// Assumes each request is held until the one-cycle ack that ends it.
`timescale 1ns/1ps
module lsu_mem_model (
    // Data port.
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [3:0]  be_i,
    input  wire logic [31:0] wdata_i,
    output logic [31:0]      rdata_o = 32'h0,
    output logic             ack_o = 1'b0
);
    logic [31:0] mem_r [0:255];
    logic [1:0]  wait_r = 2'h0;
    logic        slow_r = 1'b0;
    // Answers alternate prompt and slow; idle read data toggles, never stale.
    always @(posedge clk_i) begin
        ack_o   <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o && wait_r == {slow_r, 1'b0}) begin
            ack_o   <= 1'b1;
            wait_r  <= 2'h0;
            slow_r  <= ~slow_r;
            rdata_o <= mem_r[addr_i[9:2]];
            for (int b = 0; b < 4; b++)
                if (we_i && be_i[b]) mem_r[addr_i[9:2]][8*b +: 8] <= wdata_i[8*b +: 8];
        end else if (req_i && !ack_o) begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule // lsu_mem_model

/* File: tb_top.sv */
// Self-checking bench: load/store unit against the memory model.
// Assumes the design files and lsu_mem_model are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic        clk = 0, rst = 1, vld = 0, wr = 0, fwr = 0, flt, brs;
    logic        done, fault, br, tb, req, we, ack, rdy;
    logic [15:0] ins = 16'h0;
    logic [31:0] wd = 0, rdat, rd, wdat, adr, badr, seed = 32'd13, d0, v, ia = 32'h100, ea;
    logic [3:0]  sel = 0, fl = 0, be, flo;
    int          miscompares = 0, n_compared = 0;
    always #4 clk = ~clk;
    lsu_top lsu_top_inst (.REF_CLK_I(clk), .RST_I(rst), .INSTR_I(ins),
        .INSTR_ADDR_I(ia), .INSTR_VALID_I(vld), .READY_O(rdy), .DONE_O(done),
        .FAULT_O(fault), .BRANCH_O(br), .BRANCH_ADDR_O(badr), .TBIT_O(tb),
        .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_ADDR_O(adr), .MEM_BE_O(be),
        .MEM_WDATA_O(wdat), .MEM_RDATA_I(rd), .MEM_ACK_I(ack), .REG_WR_I(wr),
        .REG_SEL_I(sel), .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .FLAGS_WR_I(fwr),
        .FLAGS_I(fl), .FLAGS_O(flo));
    lsu_mem_model lsu_mem_model_inst (.clk_i(clk), .req_i(req), .we_i(we),
        .addr_i(adr), .be_i(be), .wdata_i(wdat), .rdata_o(rd), .ack_o(ack));
    // ****************************
    // Helpers
    // ****************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] sx8(input logic [7:0] b);
        return {{24{b[7]}}, b};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Register writes are honoured only while the unit is idle.
    task automatic wreg(input logic [3:0] s, input logic [31:0] x);
        @(posedge clk);
        wr  <= 1;
        sel <= s;
        wd  <= x;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rreg(input logic [3:0] s);
        @(posedge clk);
        sel <= s;
        @(posedge clk);
        #1 v = rdat;
    endtask
    // Valid drops at the taking edge so a still-ready unit takes it once.
    task automatic run(input logic [15:0] op);
        int n = 0;
        @(posedge clk);
        ins <= op;
        vld <= 1;
        @(posedge clk);
        vld <= 0;
        // Short answers stand only in the cycle right after the taking edge.
        #1;
        while (!(done || fault) && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        flt = fault;
        brs = br;
        chk(32'({done || fault, rdy}), 32'h3);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        repeat (40) seed = lfsr(seed);
        d0 = seed;
        seed = lfsr(seed);
        ia <= {16'h0, seed[14:0], 1'b0};
        wreg(4'hd, 32'h100);
        wreg(4'he, 32'h200);
        wreg(4'h0, d0);
        wreg(4'h1, 32'h40);
        @(posedge clk);
        fwr <= 1;
        fl  <= 4'ha;
        @(posedge clk);
        fwr <= 0;
        run(16'ha205);
        rreg(4'h2);
        ea = ((ia + 32'h4) & 32'hffff_fffc) + 32'h14;
        chk(v, ea);
        $display("address generate ended");
        run(16'h6048);
        chk(lsu_mem_model_inst.mem_r[17], d0);
        run(16'h79cb);
        rreg(4'h3);
        chk(v, {24'h0, d0[31:24]});
        for (int k = 0; k < 4; k++) begin
            wreg(4'h5, 32'(k) + 32'h4);
            run(16'h574c);
            rreg(4'h4);
            chk(v, sx8(d0[8*k +: 8]));
        end
        wreg(4'h5, 32'h6);
        run(16'h5f4c);
        rreg(4'h4);
        chk(v, {{16{d0[31]}}, d0[31:16]});
        run(16'h5d4c);
        rreg(4'h4);
        chk(v, {24'h0, d0[23:16]});
        run(16'h5548);
        chk(32'(lsu_mem_model_inst.mem_r[17][23:16]), 32'(d0[7:0]));
        run(16'h594b);
        chk(32'(flt), 32'h1);
        run(16'h0000);
        chk(32'(flt), 32'h0);
        $display("single transfers ended");
        run(16'hb501);
        chk(lsu_mem_model_inst.mem_r[62], d0);
        chk(lsu_mem_model_inst.mem_r[63], 32'h200);
        run(16'h9e01);
        rreg(4'h6);
        chk(v, 32'h200);
        run(16'hbd10);
        chk(badr, 32'h200);
        chk(32'({tb, brs}), 32'h1);
        rreg(4'hd);
        chk(v, 32'h100);
        rreg(4'h4);
        chk(v, d0);
        $display("push and pop ended");
        run(16'hc10c);
        chk(lsu_mem_model_inst.mem_r[16], ea);
        rreg(4'h1);
        chk(v, 32'h48);
        chk(32'(flo), 32'ha);
        $display("multiple and flags ended");
        conclude();
    end
    initial begin
        #60000;
        miscompares++;
        conclude();
    end
endmodule // tb_top
